//--- logic/or_alu.v
// Purpose: bitwise or with negative and zero flag results
// Assumes: same clock domain, purely combinational
// Notes: shared by both or instructions
`timescale 1ns/1ps
`default_nettype none
module or_alu #(
  parameter W = 8
) (
  input wire [W-1:0] a_i,
  input wire [W-1:0] b_i,
  output wire [W-1:0] y_o,
  output wire neg_o,
  output wire zero_o
);
  assign y_o = a_i | b_i;
  assign neg_o = y_o[W-1];
  assign zero_o = (y_o == {W{1'b0}});
endmodule // or_alu
`default_nettype wire

//--- logic/or_ptr_decoder.v
// Purpose: decode/execute literal-or, file-or and two-word pointer load
// Assumes: one instruction word per cycle, data memory read is combinational
// Notes: other opcodes are not executed here; a valid one aborts a waiting pointer load
`timescale 1ns/1ps
`default_nettype none
`include "or_ptr_defs.vh"
module or_ptr_decoder #(
  parameter AW = 12
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [3:0] bank_select_register_i,
  input wire [7:0] mem_rdata_i,
  output wire [AW-1:0] mem_addr_o,
  output wire mem_we_o,
  output wire [7:0] mem_wdata_o,
  output wire [7:0] acc_o,
  output wire flag_neg_o,
  output wire flag_zero_o,
  output wire [3:0] pointer_high_half0_o,
  output wire [7:0] pointer_low_half0_o,
  output wire [3:0] pointer_high_half1_o,
  output wire [7:0] pointer_low_half1_o,
  output wire [3:0] pointer_high_half2_o,
  output wire [7:0] pointer_low_half2_o,
  output wire ptr_busy_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WORD2 = 1'b1;
  localparam [11:0] PTR_RST = `PTR_RESET;

  // a new instruction starts only while no pointer load is waiting
  function start_hit;
    input valid;
    input busy_in;
    input hit;
    begin
      start_hit = valid && !busy_in && hit;
    end
  endfunction

  // select 3 never gets here: the first-word decode refuses it
  function ptr_pick;
    input [1:0] sel;
    input [1:0] idx;
    begin
      ptr_pick = (sel == idx);
    end
  endfunction

  reg state_r;
  reg state_nxt;
  reg [1:0] sel_r;
  reg [1:0] sel_nxt;
  reg [7:0] acc_r;
  reg [7:0] acc_nxt;
  reg flag_neg_r;
  reg flag_neg_nxt;
  reg flag_zero_r;
  reg flag_zero_nxt;
  reg we_r;
  reg we_nxt;
  reg [7:0] wdata_r;
  reg [7:0] wdata_nxt;
  reg [3:0] ptr_hi0_r;
  reg [3:0] ptr_hi0_nxt;
  reg [7:0] ptr_lo0_r;
  reg [7:0] ptr_lo0_nxt;
  reg [3:0] ptr_hi1_r;
  reg [3:0] ptr_hi1_nxt;
  reg [7:0] ptr_lo1_r;
  reg [7:0] ptr_lo1_nxt;
  reg [3:0] ptr_hi2_r;
  reg [3:0] ptr_hi2_nxt;
  reg [7:0] ptr_lo2_r;
  reg [7:0] ptr_lo2_nxt;
  wire busy;
  wire is_or_lit;
  wire is_or_file;
  wire is_ptr_w1;
  wire is_ptr_w2;
  wire [7:0] operand;
  wire [7:0] or_res;
  wire or_neg;
  wire or_zero;
  reg [3:0] bank;

  assign busy = (state_r == ST_WORD2);
  assign ptr_busy_o = busy;
  // the two or decodes are exclusive by their upper bits
  assign is_or_lit = start_hit(instr_valid_i, busy,
    instr_i[15:8] == `OPC_OR_LIT_HI);
  assign is_or_file = start_hit(instr_valid_i, busy,
    instr_i[15:10] == `OPC_OR_FILE_HI);
  // select value 3 is not a pointer, so it does not decode
  assign is_ptr_w1 = start_hit(instr_valid_i, busy,
    instr_i[15:6] == `OPC_PTR_W1_HI && instr_i[5:4] != 2'h3);
  assign is_ptr_w2 = instr_valid_i && busy && instr_i[15:8] == `OPC_PTR_W2_HI;

  // access bank: low half maps to bank 0, high half to the top bank
  always @* begin
    if (instr_i[`BIT_ACCESS]) begin
      bank = bank_select_register_i;
    end else if (instr_i[7:0] < `ACCESS_BANK_SPLIT) begin
      bank = `ACCESS_LOW_BANK;
    end else begin
      bank = `ACCESS_HIGH_BANK;
    end
  end
  assign mem_addr_o = {bank, instr_i[7:0]};

  assign operand = is_or_lit ? instr_i[7:0] : mem_rdata_i;

  or_alu #(.W(8)) u_alu (
    .a_i(acc_r),
    .b_i(operand),
    .y_o(or_res),
    .neg_o(or_neg),
    .zero_o(or_zero)
  );

  always @* begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    acc_nxt = acc_r;
    flag_neg_nxt = flag_neg_r;
    flag_zero_nxt = flag_zero_r;
    we_nxt = 1'b0;
    wdata_nxt = wdata_r;
    ptr_hi0_nxt = ptr_hi0_r;
    ptr_lo0_nxt = ptr_lo0_r;
    ptr_hi1_nxt = ptr_hi1_r;
    ptr_lo1_nxt = ptr_lo1_r;
    ptr_hi2_nxt = ptr_hi2_r;
    ptr_lo2_nxt = ptr_lo2_r;
    if (is_or_lit || is_or_file) begin
      flag_neg_nxt = or_neg;
      flag_zero_nxt = or_zero;
    end
    if (is_or_lit) begin
      acc_nxt = or_res;
    end
    if (is_or_file) begin
      if (instr_i[`BIT_DEST]) begin
        we_nxt = 1'b1;
        wdata_nxt = or_res;
      end else begin
        acc_nxt = or_res;
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (is_ptr_w1) begin
          sel_nxt = instr_i[5:4];
          state_nxt = ST_WORD2;
          if (ptr_pick(instr_i[5:4], 2'h0)) begin
            ptr_hi0_nxt = instr_i[3:0];
          end
          if (ptr_pick(instr_i[5:4], 2'h1)) begin
            ptr_hi1_nxt = instr_i[3:0];
          end
          if (ptr_pick(instr_i[5:4], 2'h2)) begin
            ptr_hi2_nxt = instr_i[3:0];
          end
        end
      end
      ST_WORD2: begin
        // a bubble does not abort the load; any other valid word does and is dropped
        if (is_ptr_w2) begin
          state_nxt = ST_IDLE;
          if (ptr_pick(sel_r, 2'h0)) begin
            ptr_lo0_nxt = instr_i[7:0];
          end
          if (ptr_pick(sel_r, 2'h1)) begin
            ptr_lo1_nxt = instr_i[7:0];
          end
          if (ptr_pick(sel_r, 2'h2)) begin
            ptr_lo2_nxt = instr_i[7:0];
          end
        end else if (instr_valid_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      sel_r <= `SEL_RESET;
      acc_r <= `ACC_RESET;
      flag_neg_r <= `FLAG_RESET;
      flag_zero_r <= `FLAG_RESET;
      we_r <= 1'b0;
      wdata_r <= `WDATA_RESET;
      ptr_hi0_r <= PTR_RST[11:8];
      ptr_lo0_r <= PTR_RST[7:0];
      ptr_hi1_r <= PTR_RST[11:8];
      ptr_lo1_r <= PTR_RST[7:0];
      ptr_hi2_r <= PTR_RST[11:8];
      ptr_lo2_r <= PTR_RST[7:0];
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      acc_r <= acc_nxt;
      flag_neg_r <= flag_neg_nxt;
      flag_zero_r <= flag_zero_nxt;
      we_r <= we_nxt;
      wdata_r <= wdata_nxt;
      ptr_hi0_r <= ptr_hi0_nxt;
      ptr_lo0_r <= ptr_lo0_nxt;
      ptr_hi1_r <= ptr_hi1_nxt;
      ptr_lo1_r <= ptr_lo1_nxt;
      ptr_hi2_r <= ptr_hi2_nxt;
      ptr_lo2_r <= ptr_lo2_nxt;
    end
  end

  // write-back address is not registered: the memory side must latch mem_addr_o
  assign mem_we_o = we_r;
  assign mem_wdata_o = wdata_r;
  assign acc_o = acc_r;
  assign flag_neg_o = flag_neg_r;
  assign flag_zero_o = flag_zero_r;
  assign pointer_high_half0_o = ptr_hi0_r;
  assign pointer_low_half0_o = ptr_lo0_r;
  assign pointer_high_half1_o = ptr_hi1_r;
  assign pointer_low_half1_o = ptr_lo1_r;
  assign pointer_high_half2_o = ptr_hi2_r;
  assign pointer_low_half2_o = ptr_lo2_r;
endmodule // or_ptr_decoder
`default_nettype wire

//--- logic/or_ptr_defs.vh
// Purpose: constants for the or / pointer-load decode block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes: definitions only
`ifndef OR_PTR_DEFS_VH
`define OR_PTR_DEFS_VH
`define OPC_OR_LIT_HI 8'h09
`define OPC_OR_FILE_HI 6'h04
`define OPC_PTR_W1_HI 10'h3b8
`define OPC_PTR_W2_HI 8'hf0
`define ACCESS_BANK_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hf
`define ACCESS_LOW_BANK 4'h0
`define ACC_RESET 8'h00
`define PTR_RESET 12'h000
`define FLAG_RESET 1'b0
`define WDATA_RESET 8'h00
`define SEL_RESET 2'h0
`define BIT_DEST 9
`define BIT_ACCESS 8
`define NUM_POINTERS 3
`endif

//--- tb/or_ops_and_pointer_load_bench.sv
// Purpose: self-checking bench for or_ptr_decoder
// Assumes: 20 MHz clock, sync reset
// Notes: random words from an lfsr
`timescale 1ns/1ps
`default_nettype none
module or_ops_and_pointer_load_bench;
  logic core_clk_i = 0, reset_i = 1, instr_valid_i = 0, v_d = 0, mn, mz, bz, we;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0] bank_select_register_i = 4'h0;
  logic [7:0] mem_rdata_i = 8'h00, ma, r;
  logic [1:0] sel;
  logic [11:0] mp [3];
  logic [31:0] lf = 32'h00012aa8;
  logic [55:0] q [$];
  logic [11:0] aq [$];
  logic fa = 0;
  int error_cnt = 0, total_checks = 0;
  wire [11:0] mem_addr_o;
  wire mem_we_o, flag_neg_o, flag_zero_o, ptr_busy_o;
  wire [7:0] mem_wdata_o, acc_o, pointer_low_half0_o, pointer_low_half1_o, pointer_low_half2_o;
  wire [3:0] pointer_high_half0_o, pointer_high_half1_o, pointer_high_half2_o;
  wire [55:0] seen = {acc_o, flag_neg_o, flag_zero_o, mem_we_o, mem_we_o ? mem_wdata_o : 8'h00,
    pointer_high_half0_o, pointer_low_half0_o, pointer_high_half1_o, pointer_low_half1_o,
    pointer_high_half2_o, pointer_low_half2_o, ptr_busy_o};
  or_ptr_decoder uut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .bank_select_register_i(bank_select_register_i),
    .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .flag_neg_o(flag_neg_o),
    .flag_zero_o(flag_zero_o), .pointer_high_half0_o(pointer_high_half0_o),
    .pointer_low_half0_o(pointer_low_half0_o), .pointer_high_half1_o(pointer_high_half1_o),
    .pointer_low_half1_o(pointer_low_half1_o), .pointer_high_half2_o(pointer_high_half2_o),
    .pointer_low_half2_o(pointer_low_half2_o), .ptr_busy_o(ptr_busy_o)
  );
  always #25 core_clk_i = ~core_clk_i;
  function automatic [31:0] nx(input [31:0] x);
    nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [55:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %h %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic op(input [15:0] w, input v);
    lf = nx(lf);
    @(posedge core_clk_i);
    instr_i <= w;
    instr_valid_i <= v;
    mem_rdata_i <= lf[7:0];
    bank_select_register_i <= lf[11:8];
    fa <= v && !bz && w[15:10] == 6'h04;
    if (v && !bz && w[15:10] == 6'h04)
      aq.push_back(w[8] ? {lf[11:8], w[7:0]} : {{4{w[7]}}, w[7:0]});
    r = ma | (w[15:8] == 8'h09 ? w[7:0] : lf[7:0]);
    we = 0;
    if (!v) return;
    if (bz) begin
      if (w[15:8] == 8'hf0) mp[sel][7:0] = w[7:0];
      bz = 0;
    end else if (w[15:8] == 8'h09 || w[15:10] == 6'h04) begin
      we = w[15:10] == 6'h04 && w[9];
      if (!we) ma = r;
      mn = r[7];
      mz = r == 8'h00;
    end else if (w[15:6] == 10'h3b8 && w[5:4] != 2'h3) begin
      sel = w[5:4];
      mp[sel][11:8] = w[3:0];
      bz = 1;
    end
    q.push_back({ma, mn, mz, we, we ? r : 8'h00, mp[0], mp[1], mp[2], bz});
  endtask
  task automatic rst;
    @(posedge core_clk_i);
    reset_i <= 1;
    instr_valid_i <= 0;
    fa <= 0;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 0;
    {ma, mn, mz, bz} = 0;
    mp = '{default: 12'h000};
  endtask
  always @(posedge core_clk_i) v_d <= instr_valid_i & !reset_i;
  always @(negedge core_clk_i)
    if (v_d) chk(seen, q.pop_front());
  always @(negedge core_clk_i)
    if (fa) chk(mem_addr_o, aq.pop_front());
  initial begin
    rst;
    op(16'h099a, 1);
    op(16'h0935, 1);
    op(16'hee23, 1);
    op(16'hf0ab, 1);
    op(16'hee15, 1);
    op(16'h0901, 1);
    // aborts and idle gaps inside pointer loads arise from the mix below
    repeat (400) begin
      lf = nx(lf);
      case (lf[13:12])
        2'h0: op({8'h09, lf[7:0]}, 1);
        2'h1: op({6'h04, lf[9:0]}, 1);
        2'h2: op({10'h3b8, lf[5:0]}, 1);
        2'h3: op({8'hf0, lf[7:0]}, lf[14]);
      endcase
    end
    rst;
    op(16'h0900, 1);
    repeat (2) @(posedge core_clk_i);
    if (q.size() != 0 || aq.size() != 0) error_cnt++;
    print_verdict;
  end
endmodule // or_ops_and_pointer_load_bench
`default_nettype wire

//--- tb/or_ptr_decoder_monitor.sv
// Purpose: port checker for or_ptr_decoder
// Assumes: one clock, sync reset
// Notes: bound into the design
`timescale 1ns/1ps
`default_nettype none
module or_ptr_monitor (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic mem_we_o,
  input wire logic flag_neg_o,
  input wire logic flag_zero_o,
  input wire logic ptr_busy_o,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [3:0] pointer_high_half2_o,
  input wire logic [7:0] pointer_low_half2_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [7:0] acc_o,
  input wire logic [11:0] mem_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // a word taken while a pointer load waits starts no new instruction; only an 0xf0 second word is executed
  wire logic go = instr_valid_i & !ptr_busy_o;
  wire logic lit = go & instr_i[15:8] == 8'h09;
  wire logic fo = go & instr_i[15:10] == 6'h04;
  wire logic [7:0] r = acc_o | mem_rdata_i;
  wire logic [7:0] res = mem_we_o ? mem_wdata_o : acc_o;
  a_lit_or: assert property (lit |=> acc_o == $past(acc_o | instr_i[7:0]) && !mem_we_o)
    else $error("lit or");
  a_file_to_acc: assert property (fo & !instr_i[9] |=> acc_o == $past(r) && !mem_we_o)
    else $error("file or acc");
  a_file_write_back: assert property (fo & instr_i[9] |=> mem_we_o && mem_wdata_o == $past(r) && $stable(acc_o))
    else $error("write back");
  a_access_bank: assert property (fo & !instr_i[8] |-> mem_addr_o == {{4{instr_i[7]}}, instr_i[7:0]})
    else $error("access bank");
  a_bank_select: assert property (fo & instr_i[8] |-> mem_addr_o == {bank_select_register_i, instr_i[7:0]})
    else $error("bank select");
  a_or_flags: assert property (lit | fo |=> flag_neg_o == res[7] && flag_zero_o == (res == 8'h00))
    else $error("flags");
  a_ptr_first: assert property (go & instr_i[15:4] == 12'hee2 |=> ptr_busy_o && pointer_high_half2_o == $past(instr_i[3:0]))
    else $error("ptr high");
  a_ptr_second: assert property (ptr_busy_o & instr_valid_i & instr_i[15:8] == 8'hf0 |=> !ptr_busy_o && $stable(acc_o))
    else $error("ptr low");
  property p_ptr_low;
    go & instr_i[15:4] == 12'hee2 ##1 instr_valid_i & instr_i[15:8] == 8'hf0
      |=> pointer_low_half2_o == $past(instr_i[7:0]);
  endproperty
  a_ptr_low_byte: assert property (p_ptr_low)
    else $error("ptr low byte");
  c_lit: cover property (lit);
  c_wb: cover property (fo & instr_i[9]);
  c_ptr: cover property (ptr_busy_o & instr_valid_i);
endmodule // or_ptr_monitor
bind or_ptr_decoder or_ptr_monitor mon (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
  .mem_we_o(mem_we_o), .flag_neg_o(flag_neg_o), .flag_zero_o(flag_zero_o),
  .ptr_busy_o(ptr_busy_o), .instr_i(instr_i), .bank_select_register_i(bank_select_register_i),
  .pointer_high_half2_o(pointer_high_half2_o), .pointer_low_half2_o(pointer_low_half2_o),
  .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o), .acc_o(acc_o),
  .mem_addr_o(mem_addr_o)
);
`default_nettype wire
